// ===== hdl/rx_gain_pkg.sv
// Constants, register map and field layout of the receive gain and carrier sense block.
// What this block does
// - Carrier sense sets after count-plus-one high samples
// - Carrier sense clears after one or two low samples
// - Gain change hold code selects 16..48 filter clocks
// - Hold code seven freezes levels indefinitely
// - Freeze halts loops; four events trigger it
// - Extra hold 16..128 converter clocks after external events
// - Floor bit selects minimum or medium lowest step
// - Ceiling bit selects medium or maximum highest step
// - Switch point places amplifier step along gain
// - Floor one, ceiling zero fixes amplifier gain
// - Loop off takes gain from initial level
// - Hysteresis needs two samples for smallest step
// - Magnitude averaged over 2, 4, 8, 16 samples
// - Initial level loaded at turn-on, never exceeded
// - Threshold decides carrier sense and gain loop
package rx_gain_pkg;
  // Register indices; the byte address on the bus is the index times four.
  localparam logic [7:0] carrier_and_freeze_cfg_idx = 8'h11;
  localparam logic [7:0] gain_loop_cfg_idx          = 8'h12;
  localparam logic [7:0] gain_level_cfg_idx         = 8'h13;
  localparam logic [7:0] status_idx                 = 8'h14;
  localparam logic [9:0] carrier_and_freeze_cfg_addr = {carrier_and_freeze_cfg_idx, 2'b00};
  localparam logic [9:0] gain_loop_cfg_addr          = {gain_loop_cfg_idx, 2'b00};
  localparam logic [9:0] gain_level_cfg_addr         = {gain_level_cfg_idx, 2'b00};
  localparam logic [9:0] status_addr                 = {status_idx, 2'b00};
  // Reset values.
  localparam logic [7:0] carrier_and_freeze_cfg_rst = 8'h65;
  localparam logic [7:0] gain_loop_cfg_rst          = 8'h75;
  localparam logic [9:0] gain_level_cfg_rst         = 10'h318;
  // Field positions.
  localparam int cs_set_lsb = 6;
  localparam int cs_reset_bit = 5;
  localparam int hold_lsb = 2;
  localparam int extra_lsb = 0;
  localparam int floor_bit = 7;
  localparam int ceil_bit = 6;
  localparam int switch_lsb = 4;
  localparam int loop_off_bit = 3;
  localparam int hyst_bit = 2;
  localparam int avg_lsb = 0;
  localparam int thr_lsb = 5;
  // Timing and gain constants.
  localparam logic [2:0] hold_forever   = 3'h7;
  localparam logic [7:0] extra_base     = 8'h10;
  localparam logic [4:0] switch_low     = 5'h0a;
  localparam logic [4:0] switch_high    = 5'h13;
  localparam logic [4:0] gain_min       = 5'h00;
  // Amplifier gain steps.
  typedef enum logic [1:0] {
    lna_min = 2'h0, lna_med = 2'h1, lna_max = 2'h2, lna_mid_hi = 2'h3
  } lna_gain_t;
  // Freeze state machine.
  typedef enum logic [2:0] {
    st_run = 3'b001, st_hold = 3'b010, st_extra = 3'b100
  } freeze_t;
  // Hold length in filter clocks per code.
  function automatic logic [5:0] hold_len(input logic [2:0] code);
    case (code)
      3'h0: hold_len = 6'h10;
      3'h1: hold_len = 6'h14;
      3'h2: hold_len = 6'h18;
      3'h3: hold_len = 6'h1c;
      3'h4: hold_len = 6'h20;
      3'h5: hold_len = 6'h28;
      default: hold_len = 6'h30;
    endcase
  endfunction : hold_len
endpackage : rx_gain_pkg

// ===== hdl/rx_gain_carrier_sense_ctrl.sv
// Receive gain loop, freeze timing and carrier sense qualification with a Wishbone slave.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module rx_gain_carrier_sense_ctrl
  import rx_gain_pkg::*;
(
  input  wire logic        ref_clk,      // System clock, 250 MHz.
  input  wire logic        resetn,       // Synchronous reset, active low.
  input  wire logic        wb_cyc_i,     // Wishbone cycle.
  input  wire logic        wb_stb_i,     // Wishbone strobe.
  input  wire logic        wb_we_i,      // Wishbone write enable.
  input  wire logic [9:0]  wb_adr_i,     // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,     // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,     // Wishbone write data.
  output logic      [31:0] wb_dat_o,     // Wishbone read data.
  output logic             wb_ack_o,     // Wishbone acknowledge.
  input  wire logic        filt_tick,    // Filter output sample strobe, same domain.
  input  wire logic [4:0]  filt_mag,     // Filter output magnitude, same domain.
  input  wire logic        adc_tick,     // Converter clock period strobe, same domain.
  input  wire logic        rx_power_up,  // Receiver power-up pulse, same domain.
  input  wire logic        freq_switch,  // Frequency register switch pulse, same domain.
  input  wire logic        lock_lost_pin,// Synthesizer out-of-lock level from a pin.
  output logic             carrier_sense,// Qualified carrier sense.
  output logic             levels_frozen,// High while levels are frozen.
  output logic      [4:0]  vga_gain,     // Variable gain setting.
  output logic      [1:0]  lna_gain,     // Amplifier gain step.
  output logic      [4:0]  rssi_level    // Averaged magnitude.
);

  // Configuration registers.
  logic [7:0] cf_q;     // Carrier and freeze configuration.
  logic [7:0] gl_q;     // Gain loop configuration.
  logic [9:0] lv_q;     // Threshold [9:5] and initial gain level [4:0].
  logic       ack_q;    // Acknowledge flop.
  logic [31:0] rd_q;    // Read data flop.

  // Decoded fields.
  logic [1:0] cs_set;
  logic       cs_rst;
  logic [2:0] hold_code;
  logic [1:0] extra_code;
  logic       lna_floor;
  logic       lna_ceil;
  logic [1:0] sw_pt;
  logic       loop_off;
  logic       hyst;
  logic [1:0] avg_code;
  logic [4:0] init_gain;
  logic [4:0] thr;
  assign cs_set     = cf_q[cs_set_lsb +: 2];
  assign cs_rst     = cf_q[cs_reset_bit];
  assign hold_code  = cf_q[hold_lsb +: 3];
  assign extra_code = cf_q[extra_lsb +: 2];
  assign lna_floor  = gl_q[floor_bit];
  assign lna_ceil   = gl_q[ceil_bit];
  assign sw_pt      = gl_q[switch_lsb +: 2];
  assign loop_off   = gl_q[loop_off_bit];
  assign hyst       = gl_q[hyst_bit];
  assign avg_code   = gl_q[avg_lsb +: 2];
  assign init_gain  = lv_q[4:0];
  assign thr        = lv_q[thr_lsb +: 5];

  // Two-flop synchroniser for the asynchronous lock pin.
  logic lock_s1_q;
  logic lock_s2_q;
  logic lock_d_q;   // Delayed copy for edge detection.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      lock_d_q  <= 1'b0;
    end else begin
      lock_s1_q <= lock_lost_pin;
      lock_s2_q <= lock_s1_q;
      lock_d_q  <= lock_s2_q;
    end
  end

  // Wishbone slave: one wait state, answers every address, unmapped reads zero.
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cf_q  <= carrier_and_freeze_cfg_rst;
      gl_q  <= gain_loop_cfg_rst;
      lv_q  <= gain_level_cfg_rst;
      ack_q <= 1'b0;
      rd_q  <= 32'h0;
    end else begin
      ack_q <= req;
      if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i) begin
        // Writes land at the edge at which the master sees ack high.
        if (wb_adr_i == carrier_and_freeze_cfg_addr) begin
          if (wb_sel_i[0]) cf_q <= wb_dat_i[7:0];
        end else if (wb_adr_i == gain_loop_cfg_addr) begin
          if (wb_sel_i[0]) gl_q <= wb_dat_i[7:0];
        end else if (wb_adr_i == gain_level_cfg_addr) begin
          if (wb_sel_i[0]) lv_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) lv_q[9:8] <= wb_dat_i[9:8];
        end
      end
      if (req) begin
        if (wb_adr_i == carrier_and_freeze_cfg_addr) begin
          rd_q <= {24'h0, cf_q};
        end else if (wb_adr_i == gain_loop_cfg_addr) begin
          rd_q <= {24'h0, gl_q};
        end else if (wb_adr_i == gain_level_cfg_addr) begin
          rd_q <= {22'h0, lv_q};
        end else if (wb_adr_i == status_addr) begin
          rd_q <= {17'h0, rssi_level, lna_gain, vga_gain, levels_frozen, carrier_sense, 1'b0};
        end else begin
          rd_q <= 32'h0;
        end
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;

  // Freeze triggers: gain change, frequency switch, lock loss, power-up.
  logic gain_changed;
  logic ext_event;
  assign ext_event = freq_switch || rx_power_up || (lock_s2_q && !lock_d_q);

  // Freeze state machine with the filter-clock hold and the converter-clock extra hold.
  freeze_t    st_q;
  logic [5:0] hold_cnt_q;
  logic [7:0] extra_cnt_q;
  logic       extra_pend_q;  // An external event asked for the extra hold.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_q         <= st_run;
      hold_cnt_q   <= 6'h0;
      extra_cnt_q  <= 8'h0;
      extra_pend_q <= 1'b0;
    end else begin
      if (gain_changed || ext_event) begin
        // Any trigger restarts the hold; a pending extra hold is kept.
        st_q         <= st_hold;
        hold_cnt_q   <= hold_len(hold_code);
        extra_pend_q <= extra_pend_q || ext_event;
      end else begin
        case (st_q)
          st_hold: begin
            if (hold_code == hold_forever) begin
              st_q <= st_hold;
            end else if (filt_tick) begin
              if (hold_cnt_q <= 6'h1) begin
                if (extra_pend_q) begin
                  st_q        <= st_extra;
                  extra_cnt_q <= extra_base << extra_code;
                end else begin
                  st_q <= st_run;
                end
              end else begin
                hold_cnt_q <= hold_cnt_q - 6'h1;
              end
            end
          end
          st_extra: begin
            extra_pend_q <= 1'b0;
            if (adc_tick) begin
              if (extra_cnt_q <= 8'h1) begin
                st_q <= st_run;
              end else begin
                extra_cnt_q <= extra_cnt_q - 8'h1;
              end
            end
          end
          default: begin
            // A hold code of seven freezes the levels even without a trigger.
            if (hold_code == hold_forever) st_q <= st_hold;
          end
        endcase
      end
    end
  end
  assign levels_frozen = (st_q != st_run);

  // Magnitude averaging over a selectable power-of-two window.
  logic [8:0] acc_q;     // Running sum of up to 16 samples.
  logic [3:0] nsamp_q;   // Samples in current window.
  logic [4:0] avg_q;     // Latest average.
  logic       avg_vld_q; // One-cycle strobe for a new average.
  logic [3:0] win_last;
  logic [8:0] acc_sum;
  assign win_last = 4'((5'h2 << avg_code) - 5'h1);
  assign acc_sum  = acc_q + {4'h0, filt_mag};
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      acc_q     <= 9'h0;
      nsamp_q   <= 4'h0;
      avg_q     <= 5'h0;
      avg_vld_q <= 1'b0;
    end else begin
      avg_vld_q <= 1'b0;
      if (filt_tick && !levels_frozen) begin
        if (nsamp_q >= win_last) begin
          // The shift is widened first, so that code three does not wrap to zero.
          avg_q     <= 5'(acc_sum >> (3'(avg_code) + 3'h1));
          avg_vld_q <= 1'b1;
          acc_q     <= 9'h0;
          nsamp_q   <= 4'h0;
        end else begin
          acc_q   <= acc_sum;
          nsamp_q <= nsamp_q + 4'h1;
        end
      end
    end
  end
  assign rssi_level = avg_q;

  // Carrier sense run counters against the threshold.
  logic [1:0] hi_run_q;
  logic       lo_run_q;
  logic       cs_q;
  logic       above;
  assign above = (avg_q >= thr);
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hi_run_q <= 2'h0;
      lo_run_q <= 1'b0;
      cs_q     <= 1'b0;
    end else if (avg_vld_q) begin
      if (above) begin
        lo_run_q <= 1'b0;
        if (hi_run_q >= cs_set) cs_q <= 1'b1;
        else hi_run_q <= hi_run_q + 2'h1;
      end else begin
        hi_run_q <= 2'h0;
        if (lo_run_q || !cs_rst) cs_q <= 1'b0;
        else lo_run_q <= 1'b1;
      end
    end
  end
  assign carrier_sense = cs_q;

  // Gain loop: steps the variable gain against the threshold.
  logic [4:0] vga_q;
  logic       pend_q;    // First of two samples under hysteresis.
  logic       pend_dir_q;
  logic       dir_up;
  logic       want;
  logic       loop_on_d_q;
  assign dir_up = (avg_q < thr);
  assign want   = dir_up ? (vga_q < init_gain) : (vga_q > gain_min);
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      vga_q       <= 5'h0;
      pend_q      <= 1'b0;
      pend_dir_q  <= 1'b0;
      loop_on_d_q <= 1'b0;
    end else begin
      loop_on_d_q <= 1'b1;
      if (loop_off) begin
        vga_q  <= init_gain;
        pend_q <= 1'b0;
      end else if (!loop_on_d_q || rx_power_up) begin
        vga_q <= init_gain;
      end else if (avg_vld_q && !levels_frozen && want) begin
        if (!hyst || (pend_q && pend_dir_q == dir_up)) begin
          vga_q  <= dir_up ? vga_q + 5'h1 : vga_q - 5'h1;
          pend_q <= 1'b0;
        end else begin
          pend_q     <= 1'b1;
          pend_dir_q <= dir_up;
        end
      end else if (avg_vld_q) begin
        pend_q <= 1'b0;
      end
    end
  end
  assign vga_gain = vga_q;

  // Gain change detection feeds the freeze.
  logic [4:0] vga_prev_q;
  always_ff @(posedge ref_clk) begin
    if (!resetn) vga_prev_q <= 5'h0;
    else vga_prev_q <= vga_q;
  end
  assign gain_changed = (vga_prev_q != vga_q) && !loop_off;

  // Amplifier step selection.
  logic [4:0] sw_level;
  lna_gain_t  lo_step;
  lna_gain_t  hi_step;
  lna_gain_t  lna_d;
  always_comb begin
    lo_step = lna_floor ? lna_med : lna_min;
    hi_step = lna_ceil ? lna_max : lna_med;
    case (sw_pt)
      2'h0: sw_level = gain_min;
      2'h1: sw_level = switch_low;
      2'h2: sw_level = switch_high;
      default: sw_level = 5'h1f;
    endcase
    if (lna_floor && !lna_ceil) begin
      case (sw_pt)
        2'h0: lna_d = lna_mid_hi;
        2'h1: lna_d = lna_min;
        2'h2: lna_d = lna_med;
        default: lna_d = lna_max;
      endcase
    end else if (sw_pt == 2'h3) begin
      lna_d = lo_step;
    end else begin
      lna_d = (vga_q >= sw_level) ? hi_step : lo_step;
    end
  end
  logic [1:0] lna_q;
  always_ff @(posedge ref_clk) begin
    if (!resetn) lna_q <= 2'h0;
    else if (!levels_frozen || loop_off) lna_q <= lna_d;
  end
  assign lna_gain = lna_q;

endmodule : rx_gain_carrier_sense_ctrl

// ===== test/rx_gain_chk.sv
// Port-level assertions for the receive gain and carrier sense block.
`timescale 1ns/1ps
module rx_gain_chk (
  input wire logic       ref_clk,       // Block clock.
  input wire logic       resetn,        // Synchronous reset, active low.
  input wire logic       wb_cyc_i,      // Bus cycle.
  input wire logic       wb_stb_i,      // Bus strobe.
  input wire logic       wb_ack_o,      // Bus acknowledge.
  input wire logic       filt_tick,     // Filter sample strobe.
  input wire logic       rx_power_up,   // Receiver power-up pulse.
  input wire logic       freq_switch,   // Frequency switch pulse.
  input wire logic       lock_lost_pin, // Out-of-lock level.
  input wire logic       carrier_sense, // Qualified carrier sense.
  input wire logic       levels_frozen, // Freeze flag.
  input wire logic [4:0] rssi_level     // Averaged magnitude.
);
  // One clock domain, so the clock and the reset are given once here.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // The slave answers exactly one cycle after it takes a request.
  ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // A new average only appears at the edge that closes a sample window.
  rssi_tick_a: assert property ($changed(rssi_level) |-> $past(filt_tick))
    else $error("average changed without a sample");
  // Carrier sense moves only one or two cycles behind a fresh average.
  cs_tick_a: assert property ($changed(carrier_sense) |->
    ($past(filt_tick) || $past(filt_tick, 2) || $past(filt_tick, 3)))
    else $error("carrier sense changed without a sample");
  pwr_freeze_a: assert property (rx_power_up |-> ##[1:3] levels_frozen)
    else $error("power-up did not freeze");
  freq_freeze_a: assert property (freq_switch |-> ##[1:3] levels_frozen)
    else $error("frequency switch did not freeze");
  // The pin passes two synchroniser flops, hence the later window.
  lock_freeze_a: assert property ($rose(lock_lost_pin) |-> ##[2:6] levels_frozen)
    else $error("lock loss did not freeze");
  // The shortest hold is sixteen filter samples, at most one per cycle.
  freeze_min_a: assert property ($rose(levels_frozen) |=> levels_frozen [*8])
    else $error("freeze too short");
endmodule : rx_gain_chk

bind rx_gain_carrier_sense_ctrl rx_gain_chk u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .filt_tick(filt_tick), .rx_power_up(rx_power_up),
  .freq_switch(freq_switch), .lock_lost_pin(lock_lost_pin),
  .carrier_sense(carrier_sense), .levels_frozen(levels_frozen), .rssi_level(rssi_level));

// ===== test/tb.sv
// Self-checking bench for the receive gain and carrier sense block.
`timescale 1ns/1ps
module tb;
  import rx_gain_pkg::*;
  logic        ref_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o; // Clock, reset, bus.
  logic [9:0]  wb_adr_i;                                              // Bus byte address.
  logic [3:0]  wb_sel_i;                                              // Bus byte selects.
  logic [31:0] wb_dat_i, wb_dat_o, rd;                                // Bus data, last read.
  logic        filt_tick, adc_tick, rx_power_up, freq_switch, lock_lost_pin; // Events.
  logic        carrier_sense, levels_frozen;                          // Status levels.
  logic [4:0]  filt_mag, vga_gain, rssi_level, v;                     // Levels, scratch.
  logic [1:0]  lna_gain;                                              // Amplifier step.
  int          num_errors, n_tests, cyc_cnt;                          // Bookkeeping.
  int          ht[7] = '{16, 20, 24, 28, 32, 40, 48};                 // Hold lengths.
  lna_gain_t   lna_t[4] = '{lna_mid_hi, lna_min, lna_med, lna_max};   // Fixed steps.
  logic [9:0]  adr_t[4] = '{carrier_and_freeze_cfg_addr, gain_loop_cfg_addr,
                            gain_level_cfg_addr, 10'h3fc};
  logic [31:0] rst_t[4] = '{32'h65, 32'h75, 32'h318, 32'h0};

  rx_gain_carrier_sense_ctrl u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .filt_tick(filt_tick), .filt_mag(filt_mag),
    .adc_tick(adc_tick), .rx_power_up(rx_power_up), .freq_switch(freq_switch),
    .lock_lost_pin(lock_lost_pin), .carrier_sense(carrier_sense),
    .levels_frozen(levels_frozen), .vga_gain(vga_gain), .lna_gain(lna_gain),
    .rssi_level(rssi_level));

  // Free-running 250 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Cuts a hang short; the whole run needs well under this many cycles.
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  // One classic bus cycle; entered just after an edge, holds until ack is seen.
  task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= we ? 4'hf : 4'($urandom);
    // Only the bench timeout ends a wait for ack.
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask : wb

  function automatic logic [4:0] hi();
    return 5'(24 + $urandom % 8);
  endfunction : hi

  function automatic logic [4:0] lo();
    return 5'($urandom % 24);
  endfunction : lo

  // One averaged sample of two equal magnitudes, then time for carrier sense to move.
  task automatic smp(input logic [4:0] m);
    filt_mag  <= m;
    filt_tick <= 1'b1;
    repeat (2) @(posedge ref_clk);
    filt_tick <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : smp

  // Steady magnitude with a sample every cycle, long enough for the gain loop to settle.
  task automatic run(input logic [4:0] m);
    filt_mag  <= m;
    filt_tick <= 1'b1;
    repeat (600) @(posedge ref_clk);
    filt_tick <= 1'b0;
    @(posedge ref_clk);
  endtask : run

  // Keeps samples flowing until any running freeze has ended.
  task automatic thaw();
    filt_tick <= 1'b1;
    adc_tick  <= 1'b1;
    for (int w = 0; w < 500 && levels_frozen !== 1'b0; w++) @(posedge ref_clk);
    filt_tick <= 1'b0;
    adc_tick  <= 1'b0;
    @(posedge ref_clk);
  endtask : thaw

  // Fires one external event and measures the freeze length with ticks every cycle.
  task automatic frz(input int h, input int e, input int ev);
    int n;
    int ex;
    n  = 0;
    ex = ht[h] + (16 << e);
    wb(1'b1, carrier_and_freeze_cfg_addr, 32'(8'h20 | (h << 2) | e));
    filt_tick     <= 1'b1;
    adc_tick      <= 1'b1;
    rx_power_up   <= (ev == 0);
    freq_switch   <= (ev == 1);
    lock_lost_pin <= (ev == 2);
    @(posedge ref_clk);
    rx_power_up <= 1'b0;
    freq_switch <= 1'b0;
    for (int w = 0; w < 500; w++) begin
      @(posedge ref_clk);
      if (levels_frozen === 1'b1) n++;
      else if (n > 0) break;
    end
    chk(n, ex, "freeze length");
    thaw();
    lock_lost_pin <= 1'b0;
  endtask : frz

  task automatic report_and_stop();
    $display("n_tests %0d num_errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence.
  initial begin
    {resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {filt_tick, filt_mag, adc_tick, rx_power_up, freq_switch, lock_lost_pin} = '0;
    void'($urandom(93080));
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    chk(levels_frozen, 1'b0, "frozen after reset");
    wb(1'b1, 10'h3fc, 32'hff);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, adr_t[i], 32'h0);
      chk(rd, rst_t[i], "reset value");
    end
    $display("test registers done");
    // Loop off: gain comes straight from the initial level.
    wb(1'b1, gain_loop_cfg_addr, 32'h7c);
    for (int i = 0; i < 3; i++) begin
      v = 5'($urandom);
      wb(1'b1, gain_level_cfg_addr, {22'h0, 5'h18, v});
      wb(1'b0, status_addr, 32'h0);
      chk(vga_gain, v, "gain from initial level");
      chk(rd[7:3], v, "status gain");
    end
    thaw();
    $display("test loop off done");
    // A steady magnitude must average to itself for every window length.
    for (int c = 0; c < 4; c++) begin
      v = 5'($urandom);
      wb(1'b1, gain_loop_cfg_addr, {24'h0, 6'h1f, c[1:0]});
      filt_mag  <= v;
      filt_tick <= 1'b1;
      repeat (4 << c) @(posedge ref_clk);
      filt_tick <= 1'b0;
      @(posedge ref_clk);
      chk(rssi_level, v, "average");
    end
    wb(1'b1, gain_loop_cfg_addr, 32'h7c);
    // Thawing left one sample of a two-sample window taken; one more tick closes it.
    filt_tick <= 1'b1;
    @(posedge ref_clk);
    filt_tick <= 1'b0;
    $display("test averaging done");
    // Set count n, clear count n[0], with a broken run in between.
    for (int n = 0; n < 4; n++) begin
      wb(1'b1, carrier_and_freeze_cfg_addr, {24'h0, n[1:0], n[0], 5'h00});
      repeat (2) smp(lo());
      chk(carrier_sense, 1'b0, "cs cleared");
      repeat (n) smp(hi());
      smp(lo());
      repeat (n) smp(hi());
      chk(carrier_sense, 1'b0, "run restarted");
      smp(hi());
      chk(carrier_sense, 1'b1, "cs set");
      smp(lo());
      chk(carrier_sense, n[0], "one low sample");
      smp(lo());
      chk(carrier_sense, 1'b0, "two low samples");
    end
    $display("test carrier sense done");
    for (int h = 0; h < 7; h++) frz(h, $urandom % 4, h % 3);
    $display("test freeze done");
    wb(1'b1, carrier_and_freeze_cfg_addr, 32'h3c);
    filt_tick <= 1'b1;
    adc_tick  <= 1'b1;
    repeat (300) @(posedge ref_clk);
    chk(levels_frozen, 1'b1, "frozen with no timeout");
    wb(1'b1, carrier_and_freeze_cfg_addr, 32'h20);
    thaw();
    chk(levels_frozen, 1'b0, "released after code change");
    $display("test endless freeze done");
    // Floor on, ceiling off: the switch point fixes the amplifier step.
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, gain_loop_cfg_addr, {24'h0, 2'b10, s[1:0], 4'hc});
      for (int w = 0; w < 8 && lna_gain !== lna_t[s]; w++) @(posedge ref_clk);
      chk(lna_gain, lna_t[s], "fixed amplifier step");
    end
    $display("test amplifier done");
    // Gain loop on: a window of two holds only one magnitude, so two ticks give one average.
    wb(1'b1, gain_level_cfg_addr, 32'h314);
    v = hi();
    smp(v);
    wb(1'b1, gain_loop_cfg_addr, 32'h64);
    smp(v);
    chk(vga_gain, 5'h14, "first strong average held");
    smp(v);
    chk(vga_gain, 5'h13, "second strong average steps");
    wb(1'b1, gain_loop_cfg_addr, 32'h60);
    run(v);
    chk(vga_gain, gain_min, "gain at floor");
    chk(lna_gain, lna_min, "lowest amplifier step");
    run(lo());
    chk(vga_gain, 5'h14, "gain back at initial level");
    chk(lna_gain, lna_max, "highest amplifier step");
    $display("test gain loop done");
    report_and_stop();
  end
endmodule : tb
